// >>> hdl/irq_combiner.sv
`timescale 1ns/1ns
`include "irq_entry_defines.svh"

module irq_combiner
  import irq_entry_pkg::*;
(
  // gated source view
  irq_req_if.combiner req
);

  // -----------------------------------------------------------
  // request combine
  // -----------------------------------------------------------
  // no priority encoding: one flat OR, software polls the bits
  assign req.anyReq = |(req.pending & req.enable);

endmodule // irq_combiner

// >>> hdl/irq_entry_defines.svh
`ifndef IRQ_ENTRY_DEFINES_SVH
`define IRQ_ENTRY_DEFINES_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define SYS_MODE_ADDR      8'hDF
`define GIE_BIT            3
`define SYS_MODE_RESET     8'h00

// ------------------------------------------------------------
// vector and sources
// ------------------------------------------------------------
`define VECTOR_HI_ADDR     16'h0000
`define VECTOR_LO_ADDR     16'h0001
`define NUM_SOURCES        10

`endif

// >>> hdl/irq_entry_pkg.sv
package irq_entry_pkg;

  // sequencer states of the interrupt machine cycle
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CLEAR_GIE,
    ST_PUSH_PCL,
    ST_PUSH_PCH,
    ST_PUSH_FLAGS,
    ST_FETCH_HI,
    ST_FETCH_LO,
    ST_BRANCH
  } entry_state_t;

  typedef logic [9:0] src_vec_t;

endpackage

// >>> hdl/irq_req_if.sv
`timescale 1ns/1ns
`include "irq_entry_defines.svh"

// carries the gated source view between the combiner and the sequencer
interface irq_req_if;
  logic [`NUM_SOURCES-1:0] pending;
  logic [`NUM_SOURCES-1:0] enable;
  logic                    anyReq;

  modport combiner (input pending, input enable, output anyReq);
  modport sequencer (output pending, output enable, input anyReq);
endinterface // irq_req_if

// >>> hdl/single_vector_interrupt_entry.sv
`timescale 1ns/1ns
`include "irq_entry_defines.svh"

// Summary of operation
// - Every source shares one vector at program address 0000H.
// - Global enable is bit 3 of the system mode register at DFH, 1 allows service.
// - Software may write the global enable directly, though the instructions are preferred.
// - A source requests service by setting its pending bit to 1.
// - The core pulses an acknowledge when it accepts a request.
// - There is no hardware priority; software polls the pending bits.
// - Service needs the global enable at 1 and the source enable set.
// - Acknowledge happens only at the end of the current instruction.
// - The first step of entry clears the global enable to 0.
// - Entry pushes PC low, then PC high, then flags.
// - Entry reads the high handler byte at 0000H, the low at 0001H, then branches.
// - Interrupt return restores PC and flags and sets the global enable to 1.
// - Timers A and B, four port pins, watch timer and serial tx/rx all feed the vector.

module single_vector_interrupt_entry
  import irq_entry_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,

  // peripheral pending bits and source enables
  input  wire logic        timerAPending,
  input  wire logic        timerBPending,
  input  wire logic [3:0]  extPinPending,
  input  wire logic        watchPending,
  input  wire logic        uartTxPending,
  input  wire logic        uartRxPending,
  input  wire logic [9:0]  sourceEnable,

  // register file access to the system mode register
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  output logic      [7:0]  regRdata,
  output logic             regHit,

  // instruction sequencer
  input  wire logic        instrEnd,
  input  wire logic        enableIrqInstr,
  input  wire logic        disableIrqInstr,
  input  wire logic        irqReturnInstr,
  input  wire logic [15:0] pcIn,
  input  wire logic [7:0]  flagsIn,
  input  wire logic [7:0]  popFlags,
  input  wire logic [15:0] popPc,

  // stack and program memory
  output logic             pushValid,
  output logic      [7:0]  pushData,
  output logic             fetchValid,
  output logic      [15:0] fetchAddr,
  input  wire logic [7:0]  fetchData,

  // to the core
  output logic             irqAck,
  output logic             entryBusy,
  output logic             branchValid,
  output logic      [15:0] branchAddr,
  output logic      [7:0]  flagsRestore,
  output logic             flagsRestoreValid,
  output logic             globalIrqEnable
);

  // -----------------------------------------------------------
  // state
  // -----------------------------------------------------------
  entry_state_t state_reg, state_next;
  logic [7:0]   sysMode_reg, sysMode_next;
  logic [15:0]  pcSave_reg, pcSave_next;
  logic [7:0]   flagsSave_reg, flagsSave_next;
  logic [7:0]   vecHi_reg, vecHi_next;
  logic [15:0]  branch_reg, branch_next;
  logic [7:0]   restore_reg, restore_next;
  logic         restoreV_reg, restoreV_next;
  logic         branchV_reg, branchV_next;
  src_vec_t     pendSync1_reg, pendSync2_reg;
  src_vec_t     pendRaw;

  irq_req_if req ();

  // -----------------------------------------------------------
  // decode
  // -----------------------------------------------------------
  // one compare shared by write, hit and read data so they never disagree
  function automatic logic sys_mode_sel(input logic [7:0] addr);
    return (addr == `SYS_MODE_ADDR);
  endfunction

  // -----------------------------------------------------------
  // sources
  // -----------------------------------------------------------
  // pending bits may come from other clocks, so synchronise them
  // nine pending lines fill a ten-bit vector; the top bit stays idle
  assign pendRaw = {1'b0, uartRxPending, uartTxPending, watchPending,
                    extPinPending, timerBPending, timerAPending};

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pendSync1_reg <= '0;
      pendSync2_reg <= '0;
    end
    else
    begin
      pendSync1_reg <= pendRaw;
      pendSync2_reg <= pendSync1_reg;
    end
  end

  assign req.pending = pendSync2_reg;
  assign req.enable  = sourceEnable;

  irq_combiner combiner (
    .req (req)
  );

  // -----------------------------------------------------------
  // next-state logic
  // -----------------------------------------------------------
  logic accept;
  // gate on idle sequencer, global enable and end of instruction only
  assign accept = (state_reg == ST_IDLE) && instrEnd && req.anyReq
                  && sysMode_reg[`GIE_BIT];

  always_comb
  begin
    state_next     = state_reg;
    sysMode_next   = sysMode_reg;
    pcSave_next    = pcSave_reg;
    flagsSave_next = flagsSave_reg;
    vecHi_next     = vecHi_reg;
    branch_next    = branch_reg;
    restore_next   = restore_reg;
    restoreV_next  = 1'b0;
    branchV_next   = 1'b0;
    // software access to global enable; entry clear below overrides it
    if (regWrite && sys_mode_sel(regAddr))
      sysMode_next = regWdata;
    if (enableIrqInstr)
      sysMode_next[`GIE_BIT] = 1'b1;
    if (disableIrqInstr)
      sysMode_next[`GIE_BIT] = 1'b0;
    if (irqReturnInstr && state_reg == ST_IDLE)
    begin
      sysMode_next[`GIE_BIT] = 1'b1;
      branch_next  = popPc;
      restore_next = popFlags;
      branchV_next  = 1'b1;
      restoreV_next = 1'b1;
    end
    unique case (state_reg)
      ST_IDLE:
        if (accept)
        begin
          pcSave_next    = pcIn;
          flagsSave_next = flagsIn;
          state_next     = ST_CLEAR_GIE;
        end
      ST_CLEAR_GIE:
      begin
        sysMode_next[`GIE_BIT] = 1'b0;
        state_next = ST_PUSH_PCL;
      end
      ST_PUSH_PCL:   state_next = ST_PUSH_PCH;
      ST_PUSH_PCH:   state_next = ST_PUSH_FLAGS;
      ST_PUSH_FLAGS: state_next = ST_FETCH_HI;
      ST_FETCH_HI:
      begin
        vecHi_next = fetchData;
        state_next = ST_FETCH_LO;
      end
      ST_FETCH_LO:
      begin
        branch_next = {vecHi_reg, fetchData};
        state_next  = ST_BRANCH;
      end
      ST_BRANCH:
      begin
        branchV_next = 1'b1;
        state_next   = ST_IDLE;
      end
    endcase
  end

  // -----------------------------------------------------------
  // registers
  // -----------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg     <= ST_IDLE;
      sysMode_reg   <= `SYS_MODE_RESET;
      pcSave_reg    <= 16'h0000;
      flagsSave_reg <= 8'h00;
      vecHi_reg     <= 8'h00;
      branch_reg    <= 16'h0000;
      restore_reg   <= 8'h00;
      restoreV_reg  <= 1'b0;
      branchV_reg   <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      sysMode_reg   <= sysMode_next;
      pcSave_reg    <= pcSave_next;
      flagsSave_reg <= flagsSave_next;
      vecHi_reg     <= vecHi_next;
      branch_reg    <= branch_next;
      restore_reg   <= restore_next;
      restoreV_reg  <= restoreV_next;
      branchV_reg   <= branchV_next;
    end
  end

  // -----------------------------------------------------------
  // outputs
  // -----------------------------------------------------------
  // acknowledge pulses on the accepting edge; pending bits untouched
  assign irqAck = accept;

  always_comb
  begin
    pushValid = 1'b0;
    pushData  = 8'h00;
    unique case (state_reg)
      ST_PUSH_PCL:
      begin
        pushValid = 1'b1;
        pushData  = pcSave_reg[7:0];
      end
      ST_PUSH_PCH:
      begin
        pushValid = 1'b1;
        pushData  = pcSave_reg[15:8];
      end
      ST_PUSH_FLAGS:
      begin
        pushValid = 1'b1;
        pushData  = flagsSave_reg;
      end
      default:
      begin
        pushValid = 1'b0;
        pushData  = 8'h00;
      end
    endcase
  end

  // single vector: only two fixed addresses are ever fetched
  assign fetchValid = (state_reg == ST_FETCH_HI) || (state_reg == ST_FETCH_LO);
  assign fetchAddr  = (state_reg == ST_FETCH_LO) ? `VECTOR_LO_ADDR
                                                 : `VECTOR_HI_ADDR;

  assign entryBusy         = (state_reg != ST_IDLE);
  assign branchValid       = branchV_reg;
  assign branchAddr        = branch_reg;
  assign flagsRestore      = restore_reg;
  assign flagsRestoreValid = restoreV_reg;
  assign globalIrqEnable   = sysMode_reg[`GIE_BIT];

  assign regHit   = (regRead || regWrite) && sys_mode_sel(regAddr);
  assign regRdata = (regRead && sys_mode_sel(regAddr)) ? sysMode_reg : 8'h00;

endmodule // single_vector_interrupt_entry

// >>> tb/irq_entry_sva.sv
`timescale 1ns/1ns
module irq_entry_sva (
  // watched ports
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWdata,
  input wire logic [7:0]  regRdata,
  input wire logic        regHit,
  input wire logic        instrEnd,
  input wire logic        irqReturnInstr,
  input wire logic        irqAck,
  input wire logic        entryBusy,
  input wire logic        pushValid,
  input wire logic        fetchValid,
  input wire logic [15:0] fetchAddr,
  input wire logic        branchValid,
  input wire logic        flagsRestoreValid,
  input wire logic        globalIrqEnable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  AST_ACK_GATED: assert property (irqAck |-> instrEnd && globalIrqEnable)
    else $error("ack outside end of instruction or with global enable off");
  AST_GIE_CLEAR: assert property (irqAck |=> entryBusy ##1 !globalIrqEnable)
    else $error("global enable not cleared by entry");
  AST_PUSH_THREE: assert property (irqAck |-> ##2 pushValid [*3] ##1 !pushValid)
    else $error("entry did not push three bytes");
  AST_VEC_FETCH: assert property (irqAck |-> ##5 fetchValid && fetchAddr == 16'h0000
    ##1 fetchValid && fetchAddr == 16'h0001) else $error("vector fetch order wrong");
  AST_BRANCH: assert property (irqAck |-> ##8 branchValid)
    else $error("no branch after vector fetch");
  AST_RETURN: assert property (irqReturnInstr && !entryBusy && !regWrite |=>
    globalIrqEnable && flagsRestoreValid && branchValid) else $error("return incomplete");
  AST_REG_WRITE: assert property (regWrite && regAddr == 8'hDF |=>
    globalIrqEnable == $past(regWdata[3])) else $error("global enable write lost");
  AST_REG_UNMAPPED: assert property (regRead && regAddr != 8'hDF |->
    regRdata == 8'h00 && !regHit) else $error("unmapped read answered");
  COV_ENTRY: cover property (irqAck ##8 branchValid);
  COV_RETURN: cover property (irqReturnInstr ##1 flagsRestoreValid);
  COV_WRITE: cover property (regWrite && regAddr == 8'hDF);
endmodule // irq_entry_sva

// >>> tb/single_vector_interrupt_entry_tb_top.sv
`timescale 1ns/1ns
module single_vector_interrupt_entry_tb_top;
  import irq_entry_pkg::*;
  localparam logic [7:0] VHI = 8'hA5, VLO = 8'h3C;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic core_clk = 0, reset_n = 0, regWrite = 0, regRead = 0, instrEnd = 0;
  logic eiInstr = 0, diInstr = 0, retInstr = 0;
  logic [8:0] pend = '0;
  src_vec_t srcEn = '0;
  logic [7:0] regAddr = '0, regWdata = '0, flagsIn = '0, popFlags = '0, fetchData;
  logic [15:0] pcIn = '0, popPc = '0, fetchAddr, branchAddr;
  logic [7:0] regRdata, pushData, flagsRestore;
  logic regHit, pushValid, fetchValid, irqAck, entryBusy, branchValid;
  logic flagsRestoreValid, globalIrqEnable;
  int failures = 0, checks = 0;
  always #5 core_clk = ~core_clk;
  single_vector_interrupt_entry dut_u (.core_clk, .reset_n, .timerAPending(pend[0]),
    .timerBPending(pend[1]), .extPinPending(pend[5:2]), .watchPending(pend[6]),
    .uartTxPending(pend[7]), .uartRxPending(pend[8]), .sourceEnable(srcEn), .regWrite,
    .regRead, .regAddr, .regWdata, .regRdata, .regHit, .instrEnd, .enableIrqInstr(eiInstr),
    .disableIrqInstr(diInstr), .irqReturnInstr(retInstr), .pcIn, .flagsIn, .popFlags, .popPc,
    .pushValid, .pushData, .fetchValid, .fetchAddr, .fetchData, .irqAck, .entryBusy,
    .branchValid, .branchAddr, .flagsRestore, .flagsRestoreValid, .globalIrqEnable);
  vector_rom_model #(.VEC_HI(VHI), .VEC_LO(VLO)) rom_u (.fetchValid, .fetchAddr, .fetchData);
  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin failures++; $display("MISMATCH %0t %s", $time, what); end
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp16({8'h00, got}, {8'h00, exp}, what);
  endtask
  task automatic cmp1(input logic got, input logic exp, input string what);
    cmp16({15'h0000, got}, {15'h0000, exp}, what);
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    regRead = 1; regAddr = a; #2;
    cmp8(regRdata, exp, "read data");
    cmp1(regHit, hit, "read hit");
    @(negedge core_clk) regRead = 0;
  endtask
  task automatic strobe(input logic [3:0] k); // {write, return, disable, enable}
    {regWrite, retInstr, diInstr, eiInstr} = k; regAddr = 8'hDF; regWdata = 8'h08;
    @(negedge core_clk) {regWrite, retInstr, diInstr, eiInstr} = 4'h0;
  endtask
  // pending is dropped right after acknowledge, well before the return
  task automatic entry(input int s, input logic expAck);
    logic [7:0] q[$];
    logic [15:0] br;
    br = 16'h0000;
    pend[s] = 1;
    repeat (3) @(negedge core_clk);
    instrEnd = 1; #2;
    cmp1(irqAck, expAck, "acknowledge");
    @(negedge core_clk) instrEnd = 0;
    if (expAck)
    begin
      pend = '0;
      repeat (9)
      begin
        if (pushValid) q.push_back(pushData);
        if (branchValid) br = branchAddr;
        @(negedge core_clk);
      end
      cmp8(8'(q.size()), 8'h03, "push count");
      cmp8(q[0], pcIn[7:0], "pc low push");
      cmp8(q[1], pcIn[15:8], "pc high push");
      cmp8(q[2], flagsIn, "flags push");
      cmp16(br, {VHI, VLO}, "handler address");
      cmp1(globalIrqEnable, 1'b0, "enable during service");
      strobe(4'h4);
      cmp1(globalIrqEnable, 1'b1, "enable after return");
      cmp16(branchAddr, popPc, "return pc");
      cmp8(flagsRestore, popFlags, "return flags");
    end
  endtask
  initial begin #100000; failures++; complete_run; end
  initial begin
    repeat (20) @(negedge core_clk);
    reset_n = 1;
    reg_read(8'hDF, 8'h00, 1);
    reg_read(8'h40, 8'h00, 0);
    srcEn = '1;
    entry(0, 0);
    $display("test reset and blocking done");
    for (int s = 0; s < 9; s++)
    begin
      srcEn = '0;
      pcIn = 16'h5A00 + 16'(s * 3); flagsIn = 8'hC0 ^ 8'(s);
      popPc = 16'h0300 + 16'(s); popFlags = 8'h30 + 8'(s);
      if (s % 2) strobe(4'h1);
      else strobe(4'h8);
      reg_read(8'hDF, 8'h08, 1);
      entry(s, 0);
      srcEn = src_vec_t'(1) << s;
      entry(s, 1);
      $display("test source %0d done", s);
    end
    strobe(4'h2);
    reg_read(8'hDF, 8'h00, 1);
    $display("test disable done");
    complete_run;
  end
endmodule // single_vector_interrupt_entry_tb_top
bind single_vector_interrupt_entry irq_entry_sva chk_u (.core_clk, .reset_n, .regWrite,
  .regRead, .regAddr, .regWdata, .regRdata, .regHit, .instrEnd, .irqReturnInstr, .irqAck,
  .entryBusy, .pushValid, .fetchValid, .fetchAddr, .branchValid, .flagsRestoreValid,
  .globalIrqEnable);

// >>> tb/vector_rom_model.sv
`timescale 1ns/1ns
// program memory holding the one shared handler vector
module vector_rom_model #(
  parameter logic [7:0] VEC_HI = 8'hA5,
  parameter logic [7:0] VEC_LO = 8'h3C
) (
  input  wire logic        fetchValid,
  input  wire logic [15:0] fetchAddr,
  output logic      [7:0]  fetchData
);
  // unselected memory shows the inverse so a stale byte cannot pass
  always_comb
  begin
    fetchData = ~VEC_LO;
    if (fetchValid && fetchAddr == 16'h0000) fetchData = VEC_HI;
    if (fetchValid && fetchAddr == 16'h0001) fetchData = VEC_LO;
  end
endmodule // vector_rom_model
